/* File: inc/fp_conv_pkg.sv */
// Purpose: shared constants for the fp conversion and result unit
// Assumes: single precision words, 24-bit sign-extended integers
// Notes: register offsets are byte addresses on the plain port
`default_nettype none
package fp_conv_pkg;
   typedef enum logic [2:0] {
      op_mac = 3'h0,
      op_mns = 3'h1,
      op_mna = 3'h2,
      op_fix = 3'h3,
      op_float = 3'h4,
      op_recip = 3'h5
   } op_t;
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_FLAGS = 4'h4;
   localparam logic [3:0] ADDR_MASK = 4'h8;
   localparam logic [3:0] ADDR_RESULT = 4'hc;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_MODE_BIT = 1;
   localparam int FLAG_ZERO = 0;
   localparam int FLAG_STATUS = 1;
   localparam int FLAG_COND = 2;
   localparam logic [1:0] CTRL_RESET = 2'h2;
   localparam logic [2:0] MASK_RESET = 3'h0;
   localparam logic [2:0] FLAGS_RESET = 3'h0;
   localparam logic signed [11:0] EXP_BIAS = 12'h07f;
   localparam logic signed [11:0] EXP_FLOOR = 12'hc00;
   localparam logic signed [11:0] EXP_INF = 12'h0ff;
   localparam logic signed [11:0] FLOAT_EXP = 12'h096;
   localparam logic [7:0] FIX_INT_EXP = 8'h96;
   localparam logic [7:0] FIX_COND_EXP = 8'h95;
   localparam logic [7:0] RECIP_EXP = 8'hfd;
   localparam logic [31:0] CLAMP_POS = 32'h007fffff;
   localparam logic [31:0] CLAMP_NEG = 32'hff820000;
   localparam logic [31:0] RECIP_OF_ZERO = 32'h7fffffff;
   localparam logic [24:0] FIX_MAX_POS = 25'h07fffff;
   localparam logic [24:0] FIX_MAX_NEG = 25'h0800000;
endpackage
`default_nettype wire

/* File: verilog/fp_round_pack.sv */
// Purpose: round a normalised significand and pack a float word
// Assumes: mant_in has its leading one at bit 23 unless zero_in
// Notes: combinational; the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module fp_round_pack (
   input wire logic sign_in,
   input wire logic signed [11:0] exp_in,
   input wire logic [23:0] mant_in,
   input wire logic guard_in,
   input wire logic sticky_in,
   input wire logic zero_in,
   output logic [31:0] word_out,
   output logic ovf_out,
   output logic zero_out
);
   logic inc;
   logic [24:0] sum;
   logic [23:0] m;
   logic signed [11:0] e;

   assign inc = guard_in & (sticky_in | mant_in[0]);
   assign sum = {1'b0, mant_in} + {24'h000000, inc};

   always_comb begin
      if (sum[24]) begin
         m = sum[24:1];
         e = exp_in + 12'sh001;
      end else begin
         m = sum[23:0];
         e = exp_in;
      end
   end

   always_comb begin
      word_out = {sign_in, 31'h00000000};
      ovf_out = 1'b0;
      zero_out = 1'b0;
      if (zero_in || e < 12'sh001) begin
         zero_out = 1'b1;
      end else if (e >= fp_conv_pkg::EXP_INF) begin
         word_out = {sign_in, fp_conv_pkg::EXP_INF[7:0], 23'h000000};
         ovf_out = 1'b1;
      end else begin
         word_out = {sign_in, e[7:0], m[22:0]};
      end
   end
endmodule
`default_nettype wire

/* File: verilog/fp_conv_unit.sv */
// Purpose: fused mac, fix/float conversion and result conditioning
// Assumes: operands come from logic on clk_in, one op per cycle
// Notes: three-cycle pipeline for every op; flags are sticky
`timescale 1ns/1ps
`default_nettype none
module fp_conv_unit #(
   parameter int GUARD_W = 26
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic op_valid_in,
   input wire logic [2:0] op_in,
   input wire logic [31:0] opa_in,
   input wire logic [31:0] opb_in,
   input wire logic [31:0] opc_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   output logic [31:0] result_out,
   output logic result_valid_out,
   output logic irq_out
);
   localparam int W = 50 + GUARD_W;
   localparam int PT = 46 + GUARD_W;

   if (GUARD_W < 3 || GUARD_W > 60) begin : g_bad_guard
      $error("GUARD_W must lie in 3..60");
   end

   function automatic logic [W-1:0] shr_sticky(
      input logic [W-1:0] v,
      input logic [11:0] amt
   );
      logic [W-1:0] r;
      logic s;
      if (amt >= 12'(W)) begin
         r = '0;
         s = |v;
      end else begin
         r = v >> amt;
         s = |(v & ~({W{1'b1}} << amt));
      end
      return {r[W-1:1], r[0] | s};
   endfunction

   function automatic logic [6:0] lead_one(input logic [W-1:0] v);
      logic [6:0] p;
      p = '0;
      for (int i = 0; i < W; i++) begin
         if (v[i]) begin
            p = 7'(i);
         end
      end
      return p;
   endfunction

   function automatic logic is_arith(input logic [2:0] op);
      return op == fp_conv_pkg::op_mac || op == fp_conv_pkg::op_mns
         || op == fp_conv_pkg::op_mna;
   endfunction

   logic [1:0] ctrl;
   logic [2:0] flags;
   logic [2:0] mask;
   logic [2:0] next_flags;
   logic [2:0] next_mask;
   logic [2:0] ev;
   logic wr_flags;

   // stage 1: unpack and multiply
   logic za, zb, zc;
   logic [23:0] ma, mb, mc;
   logic v1, psign1, csign1, en1, mode1;
   logic [2:0] op1;
   logic [47:0] prod1;
   logic signed [11:0] pexp1, cexp1;
   logic [23:0] cm1;
   logic [31:0] a1;

   // hidden one, denormals read as zero
   assign za = opa_in[30:23] == 8'h00;
   assign zb = opb_in[30:23] == 8'h00;
   assign zc = opc_in[30:23] == 8'h00;
   assign ma = za ? 24'h000000 : {1'b1, opa_in[22:0]};
   assign mb = zb ? 24'h000000 : {1'b1, opb_in[22:0]};
   assign mc = zc ? 24'h000000 : {1'b1, opc_in[22:0]};

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         v1 <= 1'b0;
      end else begin
         v1 <= op_valid_in;
      end
   end

   // datapath carries no reset; valid bits qualify it
   always_ff @(posedge clk_in) begin
      op1 <= op_in;
      a1 <= opa_in;
      // full 48-bit product, no rounding here
      prod1 <= ma * mb;
      pexp1 <= (za | zb) ? fp_conv_pkg::EXP_FLOOR
         : {4'h0, opa_in[30:23]} + {4'h0, opb_in[30:23]} - fp_conv_pkg::EXP_BIAS;
      psign1 <= opa_in[31] ^ opb_in[31] ^ (op_in == fp_conv_pkg::op_mna);
      cm1 <= mc;
      cexp1 <= zc ? fp_conv_pkg::EXP_FLOOR : {4'h0, opc_in[30:23]};
      csign1 <= opc_in[31] ^ (op_in == fp_conv_pkg::op_mns);
      en1 <= ctrl[fp_conv_pkg::CTRL_EN_BIT];
      mode1 <= ctrl[fp_conv_pkg::CTRL_MODE_BIT];
   end

   // stage 2: align, add, normalise; fix and seed
   logic [W-1:0] x, y, s, n;
   logic signed [11:0] eb;
   logic sg, sz;
   logic [6:0] lp;
   logic [23:0] fmag;

   always_comb begin
      x = {2'b00, prod1, {GUARD_W{1'b0}}};
      y = {3'b000, cm1, {(23 + GUARD_W){1'b0}}};
      fmag = a1[23] ? 24'(-a1[23:0]) : a1[23:0];
      // small operand shifted; sticky keeps its lost bits
      if (pexp1 >= cexp1) begin
         y = shr_sticky(y, pexp1 - cexp1);
         eb = pexp1;
      end else begin
         x = shr_sticky(x, cexp1 - pexp1);
         eb = cexp1;
      end
      // zero addend leaves the exact product
      if (psign1 == csign1) begin
         s = x + y;
         sg = psign1;
      end else if (x >= y) begin
         s = x - y;
         sg = psign1;
      end else begin
         s = y - x;
         sg = csign1;
      end
      if (op1 == fp_conv_pkg::op_float) begin
         s = {3'b000, fmag, {(23 + GUARD_W){1'b0}}};
         eb = fp_conv_pkg::FLOAT_EXP;
         sg = a1[23];
      end
      sz = s == '0;
      // exact cancellation gives +0
      if (sz && psign1 != csign1) begin
         sg = 1'b0;
      end
      lp = lead_one(s);
      n = s << (7'(W - 1) - lp);
   end

   logic [7:0] fe, rs;
   logic [23:0] fm, fint;
   logic [49:0] ft;
   logic [24:0] fmag_r;
   logic [23:0] fv;
   logic fg, fs, finc, fneg, fbig, fovf;
   logic [31:0] fix_word, seed_word;
   logic fcond;

   always_comb begin
      fe = a1[30:23];
      fneg = a1[31];
      fm = (fe == 8'h00) ? 24'h000000 : {1'b1, a1[22:0]};
      rs = fp_conv_pkg::FIX_INT_EXP - fe;
      ft = {fm, 26'h0000000} >> rs;
      fbig = fe > fp_conv_pkg::FIX_INT_EXP;
      // below one half only the sticky survives
      if (fe >= fp_conv_pkg::FIX_INT_EXP) begin
         fint = fm;
         fg = 1'b0;
         fs = 1'b0;
      end else if (rs > 8'h19) begin
         fint = 24'h000000;
         fg = 1'b0;
         fs = |fm;
      end else begin
         fint = ft[49:26];
         fg = ft[25];
         fs = |ft[24:0];
      end
      // mode bit picks floor or nearest
      if (mode1) begin
         finc = fg & (fs | fint[0]);
      end else begin
         finc = fneg & (fg | fs);
      end
      fmag_r = {1'b0, fint} + {24'h000000, finc};
      fovf = fbig | (fneg ? fmag_r > fp_conv_pkg::FIX_MAX_NEG
         : fmag_r > fp_conv_pkg::FIX_MAX_POS);
      fv = fneg ? 24'(-fmag_r[23:0]) : fmag_r[23:0];
      // clamp; sign fills the top byte
      if (fovf) begin
         fix_word = fneg ? fp_conv_pkg::CLAMP_NEG : fp_conv_pkg::CLAMP_POS;
      end else begin
         fix_word = {{8{fv[23]}}, fv};
      end
      // condition only when both bits set
      fcond = 1'b0;
      if (en1 && mode1) begin
         if (op1 == fp_conv_pkg::op_fix) begin
            fcond = fe > fp_conv_pkg::FIX_COND_EXP
               || (fe == fp_conv_pkg::FIX_COND_EXP && a1[22:0] != 23'h000000);
         end else if (op1 == fp_conv_pkg::op_float) begin
            fcond = !(&a1[31:24] || ~|a1[31:24]);
         end
      end
      // seed; crude, the refinement loop must fix it up
      if (fe == 8'h00) begin
         seed_word = fp_conv_pkg::RECIP_OF_ZERO;
      end else if (fe > fp_conv_pkg::RECIP_EXP) begin
         seed_word = {a1[31], 31'h00000000};
      end else if (a1[22:0] == 23'h000000) begin
         seed_word = {a1[31], fp_conv_pkg::RECIP_EXP - fe + 8'h01, 23'h000000};
      end else begin
         seed_word = {a1[31], fp_conv_pkg::RECIP_EXP - fe, ~a1[22:0]};
      end
   end

   logic v2, sign2, guard2, sticky2, zero2, cond2;
   logic [2:0] op2;
   logic signed [11:0] exp2;
   logic [23:0] mant2;
   logic [31:0] word2;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         v2 <= 1'b0;
      end else begin
         v2 <= v1;
      end
   end

   always_ff @(posedge clk_in) begin
      op2 <= op1;
      sign2 <= sg;
      exp2 <= eb + 12'(lp) - 12'(PT);
      mant2 <= n[W-1 -: 24];
      guard2 <= n[W-25];
      sticky2 <= |n[W-26:0];
      zero2 <= sz;
      word2 <= (op1 == fp_conv_pkg::op_fix) ? fix_word : seed_word;
      cond2 <= v1 & fcond;
   end

   // stage 3: round, pack, raise events
   logic [31:0] rword;
   logic rovf, rzero, direct2;

   fp_round_pack u_round (
      .sign_in(sign2),
      .exp_in(exp2),
      .mant_in(mant2),
      .guard_in(guard2),
      .sticky_in(sticky2),
      .zero_in(zero2),
      .word_out(rword),
      .ovf_out(rovf),
      .zero_out(rzero)
   );

   assign direct2 = op2 == fp_conv_pkg::op_fix || op2 == fp_conv_pkg::op_recip;

   always_comb begin
      ev = 3'h0;
      ev[fp_conv_pkg::FLAG_ZERO] = v2 & is_arith(op2) & rzero;
      ev[fp_conv_pkg::FLAG_STATUS] = v2 & is_arith(op2) & rovf;
      ev[fp_conv_pkg::FLAG_COND] = v2 & cond2;
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         result_out <= 32'h00000000;
         result_valid_out <= 1'b0;
      end else begin
         result_valid_out <= v2;
         if (v2) begin
            result_out <= direct2 ? word2 : rword;
         end
      end
   end

   // register port; set beats a same-cycle clear
   assign wr_flags = reg_wr_in && reg_addr_in == fp_conv_pkg::ADDR_FLAGS;

   always_comb begin
      next_flags = (flags & ~(wr_flags ? reg_wdata_in[2:0] : 3'h0)) | ev;
      next_mask = mask;
      if (reg_wr_in && reg_addr_in == fp_conv_pkg::ADDR_MASK) begin
         next_mask = reg_wdata_in[2:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         flags <= fp_conv_pkg::FLAGS_RESET;
         mask <= fp_conv_pkg::MASK_RESET;
         irq_out <= 1'b0;
      end else begin
         flags <= next_flags;
         mask <= next_mask;
         irq_out <= |(next_flags & next_mask);
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         ctrl <= fp_conv_pkg::CTRL_RESET;
      end else if (reg_wr_in && reg_addr_in == fp_conv_pkg::ADDR_CTRL) begin
         ctrl <= reg_wdata_in[1:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in || !reg_rd_in) begin
         reg_rdata_out <= 32'h00000000;
      end else begin
         unique case (reg_addr_in)
            fp_conv_pkg::ADDR_CTRL: reg_rdata_out <= {30'h00000000, ctrl};
            fp_conv_pkg::ADDR_FLAGS: reg_rdata_out <= {29'h00000000, flags};
            fp_conv_pkg::ADDR_MASK: reg_rdata_out <= {29'h00000000, mask};
            fp_conv_pkg::ADDR_RESULT: reg_rdata_out <= result_out;
            default: reg_rdata_out <= 32'h00000000;
         endcase
      end
   end

   // checks on the pipeline's observable behaviour
   a_fix_latency: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      op_valid_in && op_in == fp_conv_pkg::op_fix |-> ##3 result_valid_out)
      else $error("fix result not on the third edge");

   a_float_latency: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      op_valid_in && op_in == fp_conv_pkg::op_float
      |-> ##1 v1 ##1 v2 ##1 result_valid_out)
      else $error("float result not on the third edge");

   a_int_sign_fill: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      op_valid_in && op_in == fp_conv_pkg::op_fix
      |-> ##3 result_out[31:24] == {8{result_out[23]}})
      else $error("integer result not sign extended");

   a_fix_clamp_pos: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      op_valid_in && op_in == fp_conv_pkg::op_fix && !opa_in[31]
      && opa_in[30:23] >= fp_conv_pkg::FIX_INT_EXP
      |-> ##3 result_out == fp_conv_pkg::CLAMP_POS)
      else $error("large positive fix not clamped");

   a_fix_cond_set: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      op_valid_in && op_in == fp_conv_pkg::op_fix && ctrl == 2'h3
      && opa_in[30:23] > fp_conv_pkg::FIX_COND_EXP
      |-> ##3 flags[fp_conv_pkg::FLAG_COND])
      else $error("condition not set by large fix");

   a_cond_cause: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      $rose(flags[fp_conv_pkg::FLAG_COND]) |-> $past(cond2) && $past(v2))
      else $error("condition set with no enabled conversion");

   a_no_nan: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      result_valid_out && $past(is_arith(op2)) && result_out[30:23] == 8'hff
      |-> result_out[22:0] == 23'h000000)
      else $error("arithmetic produced a nan");

   a_overflow_inf: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      $rose(flags[fp_conv_pkg::FLAG_STATUS])
      |-> result_out[30:0] == 31'h7f800000 && result_valid_out)
      else $error("status set without infinity result");

   a_zero_flush: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      $rose(flags[fp_conv_pkg::FLAG_ZERO]) |-> result_out[30:0] == 31'h00000000)
      else $error("zero flag set on non-zero result");

   a_denorm_flush: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      op_valid_in && op_in == fp_conv_pkg::op_mac && opa_in[30:23] == 8'h00
      && opc_in[30:0] == 31'h00000000 |-> ##3 result_out[30:0] == 31'h00000000)
      else $error("denormal operand not flushed");

   a_recip_zero: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      op_valid_in && op_in == fp_conv_pkg::op_recip && opa_in[30:23] == 8'h00
      |-> ##3 result_out == fp_conv_pkg::RECIP_OF_ZERO)
      else $error("seed of zero wrong");
endmodule
`default_nettype wire

/* File: verif/op_source.sv */
// Purpose: far-side instruction source feeding the op port
// Assumes: the bench asks for at most one op per clk_in cycle
// Notes: idle lines flip each cycle so a stale operand is never read
`timescale 1ns/1ps
`default_nettype none
module op_source (
   input wire logic clk_in,
   input wire logic issue_in,
   input wire logic raw_in,
   input wire logic [2:0] code_in,
   input wire logic [31:0] a_in,
   input wire logic [31:0] b_in,
   input wire logic [31:0] c_in,
   output logic op_valid_out,
   output logic [2:0] op_out,
   output logic [31:0] opa_out,
   output logic [31:0] opb_out,
   output logic [31:0] opc_out
);
   initial begin
      op_valid_out = 1'b0;
      op_out = 3'h0;
      opa_out = 32'h0;
      opb_out = 32'h0;
      opc_out = 32'h0;
   end
   always @(posedge clk_in) begin
      op_valid_out <= issue_in;
      if (issue_in) begin
         op_out <= code_in;
         opb_out <= b_in;
         opc_out <= c_in;
         if (code_in == fp_conv_pkg::op_float && !raw_in) begin
            opa_out <= {{8{a_in[23]}}, a_in[23:0]};
         end else begin
            opa_out <= a_in;
         end
      end else begin
         op_out <= ~op_out;
         opa_out <= ~opa_out;
         opb_out <= ~opb_out;
         opc_out <= ~opc_out;
      end
   end
endmodule
`default_nettype wire

/* File: verif/fp_conv_unit_bench.sv */
// Purpose: self-checking bench for the conversion and result unit
// Assumes: ops enter through op_source, registers through the plain port
// Notes: results are matched in issue order by a monitor
`timescale 1ns/1ps
`default_nettype none
module fp_conv_unit_bench;
   localparam logic [3:0] r_ctrl = fp_conv_pkg::ADDR_CTRL;
   localparam logic [3:0] r_flags = fp_conv_pkg::ADDR_FLAGS;
   localparam logic [3:0] r_mask = fp_conv_pkg::ADDR_MASK;
   localparam logic [3:0] r_res = fp_conv_pkg::ADDR_RESULT;
   localparam logic [2:0] k_mac = fp_conv_pkg::op_mac;
   localparam logic [2:0] k_mns = fp_conv_pkg::op_mns;
   localparam logic [2:0] k_mna = fp_conv_pkg::op_mna;
   localparam logic [2:0] k_fix = fp_conv_pkg::op_fix;
   localparam logic [2:0] k_flt = fp_conv_pkg::op_float;
   localparam logic [2:0] k_rcp = fp_conv_pkg::op_recip;
   logic clk_in, sys_rst_in, issue_req, raw, reg_wr, reg_rd, op_valid, result_valid, irq;
   logic [2:0] code, op_w;
   logic [3:0] reg_addr;
   logic [31:0] a_v, b_v, c_v, reg_wdata, reg_rdata, result, opa, opb, opc, e_cur;
   logic [31:0] exp_q[$];
   bit chk_q[$];
   int t_q[$];
   int err_total = 0;
   int samples_checked = 0;
   int cyc = 0;

   op_source src_u (.clk_in(clk_in), .issue_in(issue_req), .raw_in(raw), .code_in(code),
      .a_in(a_v), .b_in(b_v), .c_in(c_v), .op_valid_out(op_valid), .op_out(op_w),
      .opa_out(opa), .opb_out(opb), .opc_out(opc));
   fp_conv_unit dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .op_valid_in(op_valid),
      .op_in(op_w), .opa_in(opa), .opb_in(opb), .opc_in(opc), .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
      .reg_rdata_out(reg_rdata), .result_out(result), .result_valid_out(result_valid),
      .irq_out(irq));

   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic reg_write(input logic [3:0] addr, input logic [31:0] data);
      reg_wr <= 1'b1;
      reg_addr <= addr;
      reg_wdata <= data;
      @(posedge clk_in);
      reg_wr <= 1'b0;
      @(posedge clk_in);
   endtask

   // read data stand only in the cycle after the strobe
   task automatic reg_read(input string what, input logic [3:0] addr, input logic [31:0] exp);
      reg_rd <= 1'b1;
      reg_addr <= addr;
      @(posedge clk_in);
      reg_rd <= 1'b0;
      #1;
      check(what, exp, reg_rdata);
      @(posedge clk_in);
   endtask

   task automatic issue(input logic [2:0] op, input logic [31:0] a, input logic [31:0] b,
      input logic [31:0] c, input logic [31:0] exp, input bit chk = 1'b1, input bit bad = 1'b0);
      issue_req <= 1'b1;
      raw <= bad;
      code <= op;
      a_v <= a;
      b_v <= b;
      c_v <= c;
      exp_q.push_back(exp);
      chk_q.push_back(chk);
      @(posedge clk_in);
   endtask

   task automatic drain(input string what);
      int n;
      n = 0;
      issue_req <= 1'b0;
      @(posedge clk_in);
      while (exp_q.size() != 0 && n < 40) begin
         @(posedge clk_in);
         n++;
      end
      if (exp_q.size() != 0) begin
         $display("MISMATCH drain_%s expected 0 seen %0d", what, exp_q.size());
         err_total++;
         tally_and_finish();
      end else begin
         $display("test %s done", what);
      end
   endtask

   // sampled just after the edge so design updates have landed
   always @(posedge clk_in) begin
      #1;
      cyc++;
      if (op_valid === 1'b1) begin
         t_q.push_back(cyc);
      end
      if (result_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            $display("MISMATCH result_count expected 0 seen 1");
            err_total++;
         end else begin
            e_cur = exp_q.pop_front();
            // seen one edge before taken; result shows two edges after that
            check("latency", 32'h3, 32'(cyc - t_q.pop_front()));
            if (chk_q.pop_front()) begin
               check("result", e_cur, result);
            end
         end
      end
   end

   initial begin
      sys_rst_in = 1'b1;
      issue_req = 1'b0;
      raw = 1'b0;
      code = 3'h0;
      a_v = 32'h0;
      b_v = 32'h0;
      c_v = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      repeat (6) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      reg_read("ctrl", r_ctrl, 32'h00000002);
      reg_read("flags", r_flags, 32'h0);
      reg_read("mask", r_mask, 32'h0);
      reg_read("result", r_res, 32'h0);
      reg_read("unmapped", 4'h2, 32'h0);
      reg_write(r_res, 32'h5a5a5a5a);
      reg_write(4'h6, 32'hffffffff);
      reg_read("result_ro", r_res, 32'h0);
      reg_read("ctrl_kept", r_ctrl, 32'h00000002);
      $display("test registers done");
      issue(k_mac, 32'h40000000, 32'h40400000, 32'h3f800000, 32'h40e00000);
      issue(k_mns, 32'h40000000, 32'h40400000, 32'h3f800000, 32'h40a00000);
      issue(k_mna, 32'h40000000, 32'h40400000, 32'h3f800000, 32'hc0a00000);
      issue(k_mns, 32'h3f800001, 32'h3f800001, 32'h3f800002, 32'h28800000);
      issue(k_mac, 32'h3f800001, 32'h3f800001, 32'h0, 32'h3f800002);
      issue(k_mac, 32'h3f800001, 32'h3fc00000, 32'h0, 32'h3fc00002);
      issue(k_mac, 32'h3f800003, 32'h3fc00000, 32'h0, 32'h3fc00004);
      drain("mac");
      reg_read("flags_mac", r_flags, 32'h0);
      issue(k_fix, 32'h3fc00000, 32'h0, 32'h0, 32'h00000002);
      issue(k_fix, 32'h40200000, 32'h0, 32'h0, 32'h00000002);
      issue(k_fix, 32'hc0200000, 32'h0, 32'h0, 32'hfffffffe);
      issue(k_fix, 32'h4a800001, 32'h0, 32'h0, 32'h00400000);
      issue(k_fix, 32'h4b000000, 32'h0, 32'h0, 32'h007fffff);
      issue(k_fix, 32'hcb800000, 32'h0, 32'h0, 32'hff820000);
      issue(k_fix, 32'hcb000000, 32'h0, 32'h0, 32'hff800000);
      issue(k_fix, 32'h0, 32'h0, 32'h0, 32'h0);
      drain("fix_nearest");
      reg_read("flags_fix", r_flags, 32'h0);
      reg_write(r_ctrl, 32'h1);
      issue(k_fix, 32'h40200000, 32'h0, 32'h0, 32'h00000002);
      issue(k_fix, 32'hc0200000, 32'h0, 32'h0, 32'hfffffffd);
      issue(k_fix, 32'h4a800001, 32'h0, 32'h0, 32'h00400000);
      issue(k_fix, 32'hbf000000, 32'h0, 32'h0, 32'hffffffff);
      drain("fix_floor");
      reg_read("flags_floor", r_flags, 32'h0);
      reg_write(r_ctrl, 32'h3);
      issue(k_fix, 32'h4a800000, 32'h0, 32'h0, 32'h00400000);
      drain("fix_limit");
      reg_read("flags_limit", r_flags, 32'h0);
      issue(k_fix, 32'h4a800001, 32'h0, 32'h0, 32'h00400000);
      drain("fix_cond");
      reg_read("flags_cond", r_flags, 32'h4);
      reg_write(r_flags, 32'h4);
      issue(k_flt, 32'h01000005, 32'h0, 32'h0, 32'h0, 1'b0, 1'b1);
      drain("float_bad");
      reg_read("flags_bad", r_flags, 32'h4);
      reg_write(r_flags, 32'h4);
      issue(k_flt, 32'h00000005, 32'h0, 32'h0, 32'h40a00000);
      issue(k_flt, 32'h00ffffff, 32'h0, 32'h0, 32'hbf800000);
      issue(k_flt, 32'h007fffff, 32'h0, 32'h0, 32'h4afffffe);
      issue(k_flt, 32'h00800000, 32'h0, 32'h0, 32'hcb000000);
      issue(k_flt, 32'h0, 32'h0, 32'h0, 32'h0);
      drain("float");
      reg_read("flags_float", r_flags, 32'h0);
      reg_write(r_mask, 32'h1);
      issue(k_mac, 32'h0d800000, 32'h0d800000, 32'h0, 32'h0);
      drain("underflow");
      reg_read("flags_uf", r_flags, 32'h1);
      check("irq_set", 32'h1, {31'h0, irq});
      reg_write(r_flags, 32'h1);
      check("irq_clr", 32'h0, {31'h0, irq});
      issue(k_mns, 32'h3f800000, 32'h3f800000, 32'h3f800000, 32'h0);
      issue(k_mac, 32'h00000001, 32'h40000000, 32'h0, 32'h0);
      drain("exact_zero");
      reg_read("flags_ez", r_flags, 32'h1);
      reg_write(r_flags, 32'h1);
      issue(k_mac, 32'h00000001, 32'h40000000, 32'h3f800000, 32'h3f800000);
      issue(k_mac, 32'h3f800000, 32'h80400000, 32'h40000000, 32'h40000000);
      drain("denormal");
      reg_read("flags_dn", r_flags, 32'h0);
      reg_write(r_mask, 32'h2);
      issue(k_mac, 32'h71800000, 32'h71800000, 32'h0, 32'h7f800000);
      issue(k_mac, 32'hf1800000, 32'h71800000, 32'h0, 32'hff800000);
      drain("overflow");
      reg_read("flags_of", r_flags, 32'h2);
      check("irq_of", 32'h1, {31'h0, irq});
      reg_write(r_mask, 32'h0);
      check("irq_masked", 32'h0, {31'h0, irq});
      reg_write(r_flags, 32'h2);
      issue(k_rcp, 32'h0, 32'h0, 32'h0, 32'h7fffffff);
      issue(k_rcp, 32'h40000000, 32'h0, 32'h0, 32'h3f000000);
      drain("recip");
      reg_read("flags_rcp", r_flags, 32'h0);
      reg_read("last", r_res, 32'h3f000000);
      tally_and_finish();
   end
endmodule
`default_nettype wire
